/* tb/tb_top.sv */
// testbench: reset, directed corners and seeded random atomics
`timescale 1ns/1ps
module tb_top;
  logic         clk;
  logic         rst;
  logic         req_valid;
  logic         req_ready;
  logic [6:0]   req_cmd;
  logic [33:0]  request_address;
  logic [127:0] req_payload;
  logic         rsp_valid;
  logic [127:0] rsp_payload;
  logic         atomic_flag;
  logic         rsp_error;
  logic [127:0] mem [16];
  logic [6:0]   cmds [7];
  logic [63:0]  ra;
  int           n_fail;
  int           comparisons;
  int           seed;
  int           i;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  vatom_unit u_dut (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd),
    .request_address(request_address), .req_payload(req_payload),
    .rsp_valid(rsp_valid), .rsp_payload(rsp_payload),
    .atomic_flag(atomic_flag), .rsp_error(rsp_error));

  vatom_host u_host (.clk(clk), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd),
    .request_address(request_address), .req_payload(req_payload),
    .rsp_valid(rsp_valid), .rsp_payload(rsp_payload),
    .atomic_flag(atomic_flag), .rsp_error(rsp_error));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [127:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // memory is not reset, so the block model stays valid across this
  task automatic do_reset;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("reset_ready", req_ready, 1'b0);
    check("reset_valid", rsp_valid, 1'b0);
    check("reset_payload", rsp_payload, 128'h0);
    check("reset_flag", atomic_flag, 1'b0);
    check("reset_error", rsp_error, 1'b0);
    rst = 1'b0;
    $display("test reset done");
  endtask : do_reset

  // reference behaviour; m is the whole 16-byte block, updated in place
  function automatic void model(input logic [6:0] c, input logic [33:0] a,
    input logic [127:0] p, inout logic [127:0] m, output logic [127:0] r,
    output logic f, output logic e);
    logic [63:0]  o;
    logic [63:0]  w;
    logic [127:0] n;
    o = a[3] ? m[127:64] : m[63:0];
    w = o;
    n = m;
    r = m;
    e = 1'b0;
    case (c)
      vatom_pkg::CMD_NOT_AND_16B: n = ~(m & p);
      vatom_pkg::CMD_NOT_OR_16B:  n = ~(m | p);
      vatom_pkg::CMD_SET_16B:     n = m | p;
      vatom_pkg::CMD_TOGGLE_16B:  n = m ^ p;
      vatom_pkg::CMD_CAS_MAX_8B:  w = (p[63:0] > o) ? p[63:0] : o;
      vatom_pkg::CMD_CAS_MIN_8B:  w = (p[63:0] < o) ? p[63:0] : o;
      default: e = 1'b1;
    endcase
    f = (n != m);
    if (c[5]) begin
      f = (w != o);
      r = {64'h0, o};
      if (a[3]) n[127:64] = w;
      else n[63:0] = w;
    end
    if (e) f = 1'b0;
    m = n;
  endfunction : model

  task automatic run(input logic [6:0] c, input logic [33:0] a,
                     input logic [127:0] p, input bit chk);
    logic [127:0] m;
    logic [127:0] er;
    logic [127:0] rp;
    logic         ef;
    logic         ee;
    logic         rf;
    logic         re;
    int           lat;
    m = mem[a[7:4]];
    model(c, a, p, m, er, ef, ee);
    mem[a[7:4]] = m;
    u_host.issue(c, a, p, rp, rf, re, lat);
    check("latency", lat, 2);
    if (lat > 5) begin
      n_fail++;
      results();
    end
    if (chk) begin
      check("rsp_error", re, ee);
      check("atomic_flag", rf, ef);
      if (!ee) check("rsp_payload", rp, er);
    end
  endtask : run

  //////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h785B;
    rst = 1'b1;
    cmds = '{vatom_pkg::CMD_NOT_AND_16B, vatom_pkg::CMD_NOT_OR_16B,
             vatom_pkg::CMD_SET_16B, vatom_pkg::CMD_TOGGLE_16B,
             vatom_pkg::CMD_CAS_MAX_8B, vatom_pkg::CMD_CAS_MIN_8B, 7'h43};
    do_reset();
    // memory powers up unknown; not-or with all ones clears any block
    for (i = 0; i < 16; i++)
      run(vatom_pkg::CMD_NOT_OR_16B, {26'h0, i[3:0], 4'h0}, ~128'h0, 0);
    $display("test clear done");
    run(vatom_pkg::CMD_SET_16B, 34'h10, {64'h8000000000000000, 64'h1}, 1);
    run(vatom_pkg::CMD_CAS_MAX_8B, 34'h18, {64'h0, 64'h7FFFFFFFFFFFFFFF}, 1);
    run(vatom_pkg::CMD_CAS_MIN_8B, 34'h10, {~64'h0, 64'h1}, 1);
    run(vatom_pkg::CMD_CAS_MIN_8B, 34'h18, {64'h0, 64'h1}, 1);
    run(vatom_pkg::CMD_CAS_MAX_8B, 34'h10, {64'h0, ~64'h0}, 1);
    run(vatom_pkg::CMD_TOGGLE_16B, 34'h10, 128'h0, 1);
    run(7'h43, 34'h10, ~128'h0, 1);
    run(vatom_pkg::CMD_NOT_AND_16B, 34'h14, 128'h0, 1);
    run(vatom_pkg::CMD_TOGGLE_16B, 34'h10, 128'h0, 1);
    $display("test corners done");
    @(posedge clk);
    #1;
    do_reset();
    for (i = 0; i < 400; i++) begin
      ra = {$random(seed), $random(seed)};
      run(cmds[$unsigned($random(seed)) % 7], ra[33:0],
          {$random(seed), $random(seed), $random(seed), $random(seed)}, 1);
    end
    $display("test random done");
    results();
  end
endmodule : tb_top

/* tb/vatom_host.sv */
// host requester model: drives atomic requests and collects the replies
`timescale 1ns/1ps
module vatom_host (
  // clock
  input  wire logic         clk,
  // request
  output logic              req_valid,
  input  wire logic         req_ready,
  output logic [6:0]        req_cmd,
  output logic [33:0]       request_address,
  output logic [127:0]      req_payload,
  // response
  input  wire logic         rsp_valid,
  input  wire logic [127:0] rsp_payload,
  input  wire logic         atomic_flag,
  input  wire logic         rsp_error
);
  initial begin
    req_valid = 1'b0;
    req_cmd = 7'h00;
    request_address = 34'h0;
    req_payload = 128'h0;
  end

  //////////////////////////////////////////////////////////////////////////
  // lat counts falling clock edges from take to reply; it grows large on a hang
  task automatic issue(input logic [6:0] c, input logic [33:0] a,
                       input logic [127:0] p, output logic [127:0] rp,
                       output logic rf, output logic re, output int lat);
    int n;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_cmd = c;
    request_address = a;
    req_payload = p;
    for (n = 0; n < 20 && req_ready !== 1'b1; n++)
      @(negedge clk);
    @(posedge clk);
    #1;
    // released lines carry the inverse so a stale operand cannot pass
    req_valid = 1'b0;
    req_cmd = ~c;
    request_address = ~a;
    req_payload = ~p;
    for (n = 0; n < 20 && rsp_valid !== 1'b1; n++)
      @(negedge clk);
    // the reply is sampled high at the second falling edge after the take
    lat = n;
    rp = rsp_payload;
    rf = atomic_flag;
    re = rsp_error;
  endtask : issue
endmodule : vatom_host

/* verilog/vatom_mem.sv */
// small vault array model: one write port, registered read port
`timescale 1ns/1ps
module vatom_mem (
  // clock
  input  wire logic                           clk,
  // read port
  input  wire logic                           rd_en,
  input  wire logic [vatom_pkg::MEM_AW-1:0]   rd_addr,
  output logic      [vatom_pkg::DATA_W-1:0]   rd_data,
  // write port
  input  wire logic                           wr_en,
  input  wire logic [vatom_pkg::MEM_AW-1:0]   wr_addr,
  input  wire logic [vatom_pkg::DATA_W-1:0]   wr_data
);
  logic [vatom_pkg::DATA_W-1:0] mem_r [vatom_pkg::MEM_DEPTH];
  logic [vatom_pkg::DATA_W-1:0] rd_data_r;
  logic [vatom_pkg::DATA_W-1:0] rd_data_nxt;

  always_comb begin
    rd_data_nxt = rd_en ? mem_r[rd_addr] : rd_data_r;
  end

  always_ff @(posedge clk) begin
    rd_data_r <= rd_data_nxt;
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  assign rd_data = rd_data_r;
endmodule : vatom_mem

/* verilog/vatom_pkg.sv */
// package: command codes, widths and state encodings of the atomic unit
package vatom_pkg;
  localparam int CMD_W      = 7;
  localparam int DATA_W     = 128;
  localparam int HALF_W     = 64;
  localparam int ADDR_W     = 34;
  localparam int ADDR_SEL_B = 3;
  localparam int MEM_AW     = 4;
  localparam int MEM_DEPTH  = 16;
  localparam logic [CMD_W-1:0] CMD_NOT_AND_16B = 7'h44;
  localparam logic [CMD_W-1:0] CMD_NOT_OR_16B  = 7'h42;
  localparam logic [CMD_W-1:0] CMD_SET_16B     = 7'h41;
  localparam logic [CMD_W-1:0] CMD_TOGGLE_16B  = 7'h40;
  localparam logic [CMD_W-1:0] CMD_CAS_MAX_8B  = 7'h60;
  localparam logic [CMD_W-1:0] CMD_CAS_MIN_8B  = 7'h61;
  localparam logic [DATA_W-1:0] DATA_RST = 128'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 34'h0;
  localparam logic [CMD_W-1:0]  CMD_RST  = 7'h00;
  typedef enum logic [1:0] {
    VATOM_IDLE  = 2'b00,
    VATOM_READ  = 2'b01,
    VATOM_WRITE = 2'b10
  } vatom_state_t;
endpackage : vatom_pkg

/* verilog/vatom_unit.sv */
// atomic read-modify-write unit: bitwise 16-byte and 8-byte min/max
// Functional notes
// - not-and: store ~(mem & mask), return original
// - not-or: store ~(mem | mask), return original
// - set: store mem | mask, return original
// - toggle: store mem ^ mask, return original
// - bitwise flag set when any bit changes
// - bitwise: full 16-byte mask, 16-byte reply
// - comparisons treat operands as unsigned
// - max: write larger, return original 8 bytes
// - max flag when immediate strictly greater
// - min: write smaller, return original 8 bytes
// - min flag when immediate strictly less
// - min command code is 1100001
// - address bit 3 selects upper/lower half
// - 8-byte immediate sits in lower payload half
// - 8-byte reply: original low, upper zero
// - payload byte 0 at aligned block start
// - bit 7 most significant in each byte
`timescale 1ns/1ps
module vatom_unit (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst,
  // request
  input  wire logic                            req_valid,
  output logic                                 req_ready,
  input  wire logic [vatom_pkg::CMD_W-1:0]     req_cmd,
  input  wire logic [vatom_pkg::ADDR_W-1:0]    request_address,
  input  wire logic [vatom_pkg::DATA_W-1:0]    req_payload,
  // response
  output logic                                 rsp_valid,
  output logic [vatom_pkg::DATA_W-1:0]         rsp_payload,
  output logic                                 atomic_flag,
  output logic                                 rsp_error
);
  //////////////////////////////////////////////////////////////////////////
  localparam int HW = vatom_pkg::HALF_W;
  localparam int DW = vatom_pkg::DATA_W;

  vatom_pkg::vatom_state_t       state_r, state_nxt;
  logic [vatom_pkg::CMD_W-1:0]   cmd_r, cmd_nxt;
  logic [vatom_pkg::ADDR_W-1:0]  addr_r, addr_nxt;
  logic [DW-1:0]                 imm_r, imm_nxt;
  logic [DW-1:0]                 wdata_r, wdata_nxt;
  logic                          wr_en_r, wr_en_nxt;
  logic                          rdy_r, rdy_nxt;
  logic                          rv_r, rv_nxt;
  logic [DW-1:0]                 rp_r, rp_nxt;
  logic                          af_r, af_nxt;
  logic                          err_r, err_nxt;
  logic [DW-1:0]                 mem_rd;
  logic [DW-1:0]                 result;
  logic                          flag;
  logic                          known;
  logic [HW-1:0]                 mem_half;
  logic [HW-1:0]                 imm_half;
  logic                          upper_sel;

  // block index: the four address bits just above the 16-byte offset
  vatom_mem u_mem (
    .clk     (clk),
    .rd_en   (state_r == vatom_pkg::VATOM_IDLE && req_valid && rdy_r),
    .rd_addr (request_address[vatom_pkg::MEM_AW+3:4]),
    .rd_data (mem_rd),
    .wr_en   (wr_en_r),
    .wr_addr (addr_r[vatom_pkg::MEM_AW+3:4]),
    .wr_data (wdata_r)
  );

  //////////////////////////////////////////////////////////////////////////
  // operand selection and arithmetic; vectors keep bit 7 of each byte
  // as its msb, so no byte swapping is needed
  always_comb begin
    upper_sel = addr_r[vatom_pkg::ADDR_SEL_B];
    mem_half  = upper_sel ? mem_rd[DW-1:HW] : mem_rd[HW-1:0];
    imm_half  = imm_r[HW-1:0];
    known     = 1'b1;
    result    = mem_rd;
    flag      = 1'b0;
    case (cmd_r)
      vatom_pkg::CMD_NOT_AND_16B: begin
        result = ~(mem_rd & imm_r);
        flag   = |(result ^ mem_rd);
      end
      vatom_pkg::CMD_NOT_OR_16B: begin
        result = ~(mem_rd | imm_r);
        flag   = |(result ^ mem_rd);
      end
      vatom_pkg::CMD_SET_16B: begin
        result = mem_rd | imm_r;
        flag   = |(result ^ mem_rd);
      end
      vatom_pkg::CMD_TOGGLE_16B: begin
        result = mem_rd ^ imm_r;
        flag   = |(result ^ mem_rd);
      end
      vatom_pkg::CMD_CAS_MAX_8B: begin
        // logic vectors compare unsigned
        flag   = imm_half > mem_half;
        result = upper_sel ?
                 {(flag ? imm_half : mem_half), mem_rd[HW-1:0]} :
                 {mem_rd[DW-1:HW], (flag ? imm_half : mem_half)};
      end
      vatom_pkg::CMD_CAS_MIN_8B: begin
        flag   = imm_half < mem_half;
        result = upper_sel ?
                 {(flag ? imm_half : mem_half), mem_rd[HW-1:0]} :
                 {mem_rd[DW-1:HW], (flag ? imm_half : mem_half)};
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer: one request in flight at a time, so no second request can
  // touch the block between its read and its write-back
  always_comb begin
    state_nxt = state_r;
    cmd_nxt   = cmd_r;
    addr_nxt  = addr_r;
    imm_nxt   = imm_r;
    wdata_nxt = wdata_r;
    wr_en_nxt = 1'b0;
    rdy_nxt   = rdy_r;
    rv_nxt    = 1'b0;
    rp_nxt    = rp_r;
    af_nxt    = af_r;
    err_nxt   = err_r;
    case (state_r)
      vatom_pkg::VATOM_IDLE: begin
        rdy_nxt = 1'b1;
        if (req_valid && rdy_r) begin
          cmd_nxt   = req_cmd;
          addr_nxt  = request_address;
          imm_nxt   = req_payload;
          rdy_nxt   = 1'b0;
          state_nxt = vatom_pkg::VATOM_READ;
        end
      end
      vatom_pkg::VATOM_READ: begin
        // unknown commands answer with an error and leave memory alone
        wdata_nxt = result;
        wr_en_nxt = known;
        rv_nxt    = 1'b1;
        af_nxt    = flag;
        err_nxt   = ~known;
        if (cmd_r == vatom_pkg::CMD_CAS_MAX_8B ||
            cmd_r == vatom_pkg::CMD_CAS_MIN_8B) begin
          rp_nxt = {{HW{1'b0}}, mem_half};
        end else begin
          rp_nxt = mem_rd;
        end
        state_nxt = vatom_pkg::VATOM_WRITE;
      end
      vatom_pkg::VATOM_WRITE: begin
        // write lands this cycle; ready returns next cycle
        rdy_nxt   = 1'b1;
        state_nxt = vatom_pkg::VATOM_IDLE;
      end
      default: begin
        state_nxt = vatom_pkg::VATOM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= vatom_pkg::VATOM_IDLE;
      cmd_r   <= vatom_pkg::CMD_RST;
      addr_r  <= vatom_pkg::ADDR_RST;
      imm_r   <= vatom_pkg::DATA_RST;
      wdata_r <= vatom_pkg::DATA_RST;
      wr_en_r <= 1'b0;
      rdy_r   <= 1'b0;
      rv_r    <= 1'b0;
      rp_r    <= vatom_pkg::DATA_RST;
      af_r    <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmd_r   <= cmd_nxt;
      addr_r  <= addr_nxt;
      imm_r   <= imm_nxt;
      wdata_r <= wdata_nxt;
      wr_en_r <= wr_en_nxt;
      rdy_r   <= rdy_nxt;
      rv_r    <= rv_nxt;
      rp_r    <= rp_nxt;
      af_r    <= af_nxt;
      err_r   <= err_nxt;
    end
  end

  assign req_ready   = rdy_r;
  assign rsp_valid   = rv_r;
  assign rsp_payload = rp_r;
  assign atomic_flag = af_r;
  assign rsp_error   = err_r;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_answer;
    ##2 rsp_valid;
  endsequence

  property p_answer_two;
    s_take |-> s_answer;
  endproperty
  a_answer_two: assert property (p_answer_two) else $error("no reply");

  property p_busy;
    s_take |=> !req_ready [*2] ##1 req_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready overlap");

  property p_write_with_rsp;
    rsp_valid && !rsp_error |-> wr_en_r;
  endproperty
  a_write_with_rsp: assert property (p_write_with_rsp)
    else $error("write missing");

  property p_nand;
    rsp_valid && cmd_r == vatom_pkg::CMD_NOT_AND_16B |->
      wdata_r == ~(rsp_payload & imm_r);
  endproperty
  a_nand: assert property (p_nand) else $error("not-and wrong");

  property p_nor;
    rsp_valid && cmd_r == vatom_pkg::CMD_NOT_OR_16B |->
      wdata_r == ~(rsp_payload | imm_r);
  endproperty
  a_nor: assert property (p_nor) else $error("not-or wrong");

  property p_set;
    rsp_valid && cmd_r == vatom_pkg::CMD_SET_16B |->
      wdata_r == (rsp_payload | imm_r);
  endproperty
  a_set: assert property (p_set) else $error("set wrong");

  property p_toggle;
    rsp_valid && cmd_r == vatom_pkg::CMD_TOGGLE_16B |->
      wdata_r == (rsp_payload ^ imm_r);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle wrong");

  property p_bit_flag;
    rsp_valid && cmd_r[6:5] == 2'h2 && !rsp_error |->
      atomic_flag == (wdata_r != rsp_payload);
  endproperty
  a_bit_flag: assert property (p_bit_flag) else $error("flag wrong");

  property p_cmp_upper;
    rsp_valid && cmd_r[6:5] == 2'h3 && !rsp_error |->
      rsp_payload[DW-1:HW] == 64'h0;
  endproperty
  a_cmp_upper: assert property (p_cmp_upper) else $error("upper nonzero");

  property p_max_flag;
    rsp_valid && cmd_r == vatom_pkg::CMD_CAS_MAX_8B |->
      atomic_flag == (imm_r[HW-1:0] > rsp_payload[HW-1:0]);
  endproperty
  a_max_flag: assert property (p_max_flag) else $error("max flag");

  property p_min_flag;
    rsp_valid && cmd_r == vatom_pkg::CMD_CAS_MIN_8B |->
      atomic_flag == (imm_r[HW-1:0] < rsp_payload[HW-1:0]);
  endproperty
  a_min_flag: assert property (p_min_flag) else $error("min flag");

  property p_max_write;
    rsp_valid && cmd_r == vatom_pkg::CMD_CAS_MAX_8B |->
      (upper_sel ? wdata_r[DW-1:HW] : wdata_r[HW-1:0]) ==
      (atomic_flag ? imm_r[HW-1:0] : rsp_payload[HW-1:0]);
  endproperty
  a_max_write: assert property (p_max_write)
    else $error("max write wrong");

  property p_min_write;
    rsp_valid && cmd_r == vatom_pkg::CMD_CAS_MIN_8B |->
      (upper_sel ? wdata_r[DW-1:HW] : wdata_r[HW-1:0]) ==
      (atomic_flag ? imm_r[HW-1:0] : rsp_payload[HW-1:0]);
  endproperty
  a_min_write: assert property (p_min_write)
    else $error("min write wrong");

  // read data still holds the block here: no read since the take
  property p_half_keep;
    rsp_valid && cmd_r[6:5] == 2'h3 && !rsp_error |->
      (upper_sel ? wdata_r[HW-1:0] : wdata_r[DW-1:HW]) ==
      (upper_sel ? mem_rd[HW-1:0] : mem_rd[DW-1:HW]);
  endproperty
  a_half_keep: assert property (p_half_keep)
    else $error("other half lost");

  property p_rsp_pulse;
    rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("reply longer than one cycle");
endmodule : vatom_unit
